// *** src/sfs_pkg.sv ***
// Constants, register map and state types for the serial frame sequencer
package sfs_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DIV  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_DATA = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'hC;

  // Control register fields
  localparam int CTRL_EN     = 0;
  localparam int CTRL_MST    = 1;
  localparam int CTRL_SPO    = 2;
  localparam int CTRL_SPH    = 3;
  localparam int CTRL_FMT_LO = 4;
  localparam int CTRL_FMT_HI = 5;
  localparam int CTRL_DSS_LO = 8;
  localparam int CTRL_DSS_HI = 11;

  // Status register fields
  localparam int STAT_TXFULL = 0;
  localparam int STAT_RXVAL  = 1;
  localparam int STAT_BUSY   = 2;
  localparam int STAT_OVR    = 3;

  localparam logic [1:0] FMT_SPI = 2'h0;
  localparam logic [1:0] FMT_CMD = 2'h2;

  // Command/response framing
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] CMD_WAIT = 5'h01;

  localparam logic [7:0] DIV_RESET = 8'h04;
  localparam logic [3:0] DSS_RESET = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEAD  = 3'h1,
    ST_RUN   = 3'h3,
    ST_TAIL  = 3'h2,
    ST_GAP   = 3'h6,
    ST_SLAVE = 3'h4
  } sfs_state_type;

  typedef struct packed {
    sfs_state_type     state;
    logic              en;
    logic              mst;
    logic              clock_polarity_bit;
    logic              clock_phase_bit;
    logic [1:0]        fmt;
    logic [3:0]        dss;
    logic [7:0]        div;
    logic [DATA_W-1:0] txbuf;
    logic              txv;
    logic [DATA_W-1:0] rxbuf;
    logic              rxv;
    logic              ovr;
    logic [DATA_W-1:0] tsh;
    logic [DATA_W-1:0] rsh;
    logic [4:0]        k;
    logic [7:0]        hcnt;
    logic              lead;
    logic              tailc;
    logic              sck;
    logic              sck_oe_n;
    logic              fss;
    logic              fss_oe_n;
    logic              tx;
    logic              tx_oe_n;
    logic [DATA_W-1:0] rdata;
    logic              sck_s1;
    logic              sck_s2;
    logic              sck_s3;
    logic              fss_s1;
    logic              fss_s2;
    logic              fss_s3;
    logic              rx_s1;
    logic              rx_s2;
  } sfs_regs_type;

endpackage

// *** src/sfs_sequencer.sv ***
// Serial frame sequencer: SPI variants and command/response framing
// How it works
// - Idle: clock at polarity (low in command format), select high, data low
// - Master drives clock pad; slave takes clock in
// - Enabled with data: select low, data pad on
// - Phase 0: slave first, master half later
// - Pol 0 phase 0: capture rise, launch fall
// - Pol 1 phase 0: capture fall, launch rise
// - Phase 1: data and first edge together
// - Pol 0 phase 1: capture fall, launch rise
// - Pol 1 phase 1: first edge falls, capture rise
// - Select high one period after last capture
// - Phase 0 runs pulse select between words
// - Phase 1 runs hold select low between words
// - Command frame opens with eight-bit control word
// - Control byte write starts frame, MSB out
// - Select stays low through command frame
// - Response bits latched on rising clock edges
// - Select rise moves response into receive buffer
// - Continuous command frames keep select low
// - Continuous: push response on following falling edge
// - Command slave samples first rise after select
// - Words of 4 to 16 bits, MSB first
`timescale 1ns/1ps
module sfs_sequencer
  import sfs_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  input  wire logic              serial_clock_line_in,
  output logic                   serial_clock_line_out,
  output logic                   serial_clock_line_oe_n_out,
  input  wire logic              frame_select_line_in,
  output logic                   frame_select_line_out,
  output logic                   frame_select_line_oe_n_out,
  output logic                   serial_out_line_out,
  output logic                   serial_out_line_oe_n_out,
  input  wire logic              serial_in_line_in
);

  localparam sfs_regs_type REGS_RESET = '{
    state:    ST_IDLE,
    div:      DIV_RESET,
    dss:      DSS_RESET,
    sck_oe_n: 1'b1,
    fss:      1'b1,
    fss_oe_n: 1'b1,
    tx_oe_n:  1'b1,
    fss_s1:   1'b1,
    fss_s2:   1'b1,
    fss_s3:   1'b1,
    default:  '0
  };

  sfs_regs_type st;
  sfs_regs_type next_st;

  always_comb
  begin
    logic       mw;
    logic       idle_lvl;
    logic       cap_lead;
    logic       tick;
    logic       leading;
    logic       start;
    logic [4:0] nbits;
    logic [4:0] total;
    logic [4:0] k_new;
    logic       s_rise;
    logic       s_fall;
    logic       s_lead;
    logic       s_trail;
    logic       fss_fall;
    next_st  = st;
    mw       = (st.fmt == FMT_CMD);
    idle_lvl = st.clock_polarity_bit & ~mw;
    // Command frames capture on rising edges, like polarity 0 phase 0
    cap_lead = mw | ~st.clock_phase_bit;
    nbits    = {1'b0, st.dss} + 5'h01;
    total    = mw ? CMD_BITS + CMD_WAIT + nbits : nbits;
    tick     = (st.hcnt == st.div);
    leading  = (st.sck == idle_lvl);
    start    = 1'b0;
    k_new    = st.k + 5'h01;
    s_rise   = st.sck_s2 & ~st.sck_s3;
    s_fall   = ~st.sck_s2 & st.sck_s3;
    s_lead   = idle_lvl ? s_fall : s_rise;
    s_trail  = idle_lvl ? s_rise : s_fall;
    fss_fall = ~st.fss_s2 & st.fss_s3;

    // Pin synchronisers; stage one feeds stage two only
    next_st.sck_s1 = serial_clock_line_in;
    next_st.sck_s2 = st.sck_s1;
    next_st.sck_s3 = st.sck_s2;
    next_st.fss_s1 = frame_select_line_in;
    next_st.fss_s2 = st.fss_s1;
    next_st.fss_s3 = st.fss_s2;
    next_st.rx_s1  = serial_in_line_in;
    next_st.rx_s2  = st.rx_s1;

    // Register port; read data stands for one cycle only
    next_st.rdata = '0;
    if (wr_in)
    begin
      unique case (addr_in)
        OFS_CTRL:
        begin
          next_st.en  = wdata_in[CTRL_EN];
          next_st.mst = wdata_in[CTRL_MST];
          next_st.clock_polarity_bit = wdata_in[CTRL_SPO];
          next_st.clock_phase_bit = wdata_in[CTRL_SPH];
          next_st.fmt = wdata_in[CTRL_FMT_HI:CTRL_FMT_LO];
          next_st.dss = (wdata_in[CTRL_DSS_HI:CTRL_DSS_LO] < 4'h3) ? 4'h3
                        : wdata_in[CTRL_DSS_HI:CTRL_DSS_LO];
        end
        OFS_DIV:  next_st.div = wdata_in[7:0];
        // Writes to a full transmit holder are dropped
        OFS_DATA:
        begin
          if (!st.txv)
          begin
            next_st.txbuf = wdata_in;
            next_st.txv   = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rd_in)
    begin
      unique case (addr_in)
        OFS_CTRL:
        begin
          next_st.rdata[CTRL_EN]                 = st.en;
          next_st.rdata[CTRL_MST]                = st.mst;
          next_st.rdata[CTRL_SPO]                = st.clock_polarity_bit;
          next_st.rdata[CTRL_SPH]                = st.clock_phase_bit;
          next_st.rdata[CTRL_FMT_HI:CTRL_FMT_LO] = st.fmt;
          next_st.rdata[CTRL_DSS_HI:CTRL_DSS_LO] = st.dss;
        end
        OFS_DIV:  next_st.rdata[7:0] = st.div;
        OFS_DATA:
        begin
          next_st.rdata = st.rxbuf;
          next_st.rxv   = 1'b0;
          next_st.ovr   = 1'b0;
        end
        OFS_STAT:
        begin
          next_st.rdata[STAT_TXFULL] = st.txv;
          next_st.rdata[STAT_RXVAL]  = st.rxv;
          next_st.rdata[STAT_BUSY]   = (st.state != ST_IDLE) && (st.state != ST_SLAVE);
          next_st.rdata[STAT_OVR]    = st.ovr;
        end
        default: ;
      endcase
    end

    // Half-period divider, counting inside master frames and in the select-high gap between them
    if (st.state == ST_IDLE || st.state == ST_SLAVE || tick)
      next_st.hcnt = '0;
    else
      next_st.hcnt = st.hcnt + 8'h01;

    // clock pad follows master or slave role
    next_st.sck_oe_n = ~st.mst;
    next_st.fss_oe_n = ~st.mst;

    unique case (st.state)
      ST_IDLE:
      begin
        next_st.sck     = idle_lvl;
        next_st.fss     = 1'b1;
        next_st.tx      = 1'b0;
        next_st.tx_oe_n = 1'b1;
        // start when enabled with data waiting
        if (st.en && st.mst && st.txv)
          start = 1'b1;
        else if (st.en && !st.mst)
          next_st.state = ST_SLAVE;
      end
      ST_LEAD:
      begin
        if (tick)
        begin
          if (!mw && !st.clock_phase_bit && !st.lead)
          begin
            // master data half a period after select falls
            next_st.tx   = st.tsh[DATA_W-1];
            next_st.tsh  = {st.tsh[DATA_W-2:0], 1'b0};
            next_st.lead = 1'b1;
          end
          else
          begin
            // phase 1 launches with the first transition
            // polarity 1 makes that first edge a fall
            next_st.sck   = ~st.sck;
            next_st.k     = 5'h01;
            next_st.state = ST_RUN;
            if (!cap_lead)
            begin
              next_st.tx  = st.tsh[DATA_W-1];
              next_st.tsh = {st.tsh[DATA_W-2:0], 1'b0};
            end
            else if (!mw)
              next_st.rsh = {st.rsh[DATA_W-2:0], st.rx_s2};
          end
        end
      end
      ST_RUN:
      begin
        if (tick)
        begin
          next_st.sck = ~st.sck;
          if (leading)
          begin
            next_st.k = k_new;
            if (cap_lead)
            begin
              // phase 0 captures on leading edge
              // with polarity 1 that edge falls
              // response bits latched on rising edges
              if (!mw || k_new > CMD_BITS + CMD_WAIT)
                next_st.rsh = {st.rsh[DATA_W-2:0], st.rx_s2};
              // continuous command frames stay in RUN
              if (k_new == total && !(mw && st.txv && st.en))
              begin
                next_st.state = ST_TAIL;
                next_st.tailc = 1'b0;
              end
            end
            else
            begin
              next_st.tx  = st.tsh[DATA_W-1];
              next_st.tsh = {st.tsh[DATA_W-2:0], 1'b0};
            end
          end
          else if (cap_lead)
          begin
            if (mw && st.k == total)
            begin
              // push response on the falling edge
              next_st.rxbuf = st.rsh;
              next_st.ovr   = next_st.ovr | next_st.rxv;
              next_st.rxv   = 1'b1;
              next_st.rsh   = '0;
              next_st.txv   = 1'b0;
              next_st.k     = '0;
              next_st.tx    = st.txbuf[7];
              next_st.tsh   = {st.txbuf[6:0], 9'h000};
            end
            else if (!mw || st.k < CMD_BITS)
            begin
              // only the control word is driven out
              next_st.tx  = st.tsh[DATA_W-1];
              next_st.tsh = {st.tsh[DATA_W-2:0], 1'b0};
            end
            else
              next_st.tx = 1'b0;
          end
          else
          begin
            // phase 1 captures on trailing edge
            next_st.rsh = {st.rsh[DATA_W-2:0], st.rx_s2};
            if (st.k == total)
            begin
              next_st.state = ST_TAIL;
              next_st.tailc = 1'b0;
            end
          end
        end
      end
      ST_TAIL:
      begin
        if (tick)
        begin
          if (!leading)
            next_st.sck = ~st.sck;
          next_st.tailc = 1'b1;
          if (st.tailc)
          begin
            // select rises one period after last capture
            // and the word moves to the receive holder
            next_st.rxbuf = st.rsh;
            next_st.ovr   = next_st.ovr | next_st.rxv;
            next_st.rxv   = 1'b1;
            next_st.tx    = 1'b0;
            if (st.txv && st.en && st.clock_phase_bit && !mw)
              start = 1'b1;
            else
            begin
              next_st.fss     = 1'b1;
              next_st.tx_oe_n = 1'b1;
              // phase 0 pulses select high between words
              next_st.state   = (st.txv && st.en) ? ST_GAP : ST_IDLE;
            end
          end
        end
      end
      ST_GAP:
      begin
        if (tick)
          start = 1'b1;
      end
      ST_SLAVE:
      begin
        next_st.sck_oe_n = 1'b1;
        next_st.fss_oe_n = 1'b1;
        if (!st.en || st.mst)
          next_st.state = ST_IDLE;
        if (st.fss_s2)
        begin
          next_st.tx_oe_n = 1'b1;
          next_st.tx      = 1'b0;
        end
        else if (fss_fall)
        begin
          next_st.tx_oe_n = 1'b0;
          next_st.k       = '0;
          next_st.rsh     = '0;
          // Only a held word is consumed; a write landing now survives
          next_st.txv     = next_st.txv & ~st.txv;
          next_st.tsh     = st.txv ? st.txbuf << (4'hF - st.dss) : '0;
          if (cap_lead)
          begin
            // slave first bit as select falls
            next_st.tx  = st.txv ? st.txbuf[st.dss] : 1'b0;
            next_st.tsh = st.txv ? st.txbuf << (5'h10 - {1'b0, st.dss}) : '0;
          end
        end
        else
        begin
          // capture on leading edge for phase 0 and command frames, trailing edge for phase 1
          if (cap_lead ? s_lead : s_trail)
          begin
            next_st.rsh = {st.rsh[DATA_W-2:0], st.rx_s2};
            next_st.k   = k_new;
            if (k_new == nbits)
            begin
              next_st.rxbuf = {st.rsh[DATA_W-2:0], st.rx_s2};
              next_st.ovr   = next_st.ovr | next_st.rxv;
              next_st.rxv   = 1'b1;
              next_st.k     = '0;
              next_st.rsh   = '0;
              next_st.txv   = next_st.txv & ~st.txv;
              next_st.tsh   = st.txv ? st.txbuf << (4'hF - st.dss) : '0;
            end
          end
          if ((cap_lead ? s_trail : s_lead) && (!cap_lead || st.k != 5'h00))
          begin
            next_st.tx  = st.tsh[DATA_W-1];
            next_st.tsh = {st.tsh[DATA_W-2:0], 1'b0};
          end
        end
      end
      default: next_st.state = ST_IDLE;
    endcase

    if (start)
    begin
      // select held low for the whole frame
      next_st.state   = ST_LEAD;
      next_st.fss     = 1'b0;
      next_st.tx_oe_n = 1'b0;
      next_st.txv     = 1'b0;
      next_st.k       = '0;
      next_st.lead    = 1'b0;
      next_st.tailc   = 1'b0;
      next_st.rsh     = '0;
      next_st.sck     = idle_lvl;
      if (mw)
      begin
        // control byte MSB out as select falls
        next_st.tx  = st.txbuf[7];
        next_st.tsh = {st.txbuf[6:0], 9'h000};
      end
      else
      begin
        next_st.tx  = 1'b0;
        next_st.tsh = st.txbuf << (4'hF - st.dss);
      end
    end

    // Disabling aborts any master frame at once
    if (!st.en && st.state != ST_SLAVE && st.state != ST_IDLE)
    begin
      next_st.state   = ST_IDLE;
      next_st.fss     = 1'b1;
      next_st.tx_oe_n = 1'b1;
      next_st.tx      = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      st <= REGS_RESET;
    else
      st <= next_st;
  end

  assign rdata_out                  = st.rdata;
  assign serial_clock_line_out      = st.sck;
  assign serial_clock_line_oe_n_out = st.sck_oe_n;
  assign frame_select_line_out      = st.fss;
  assign frame_select_line_oe_n_out = st.fss_oe_n;
  assign serial_out_line_out        = st.tx;
  assign serial_out_line_oe_n_out   = st.tx_oe_n;

endmodule

// *** testbench/sfs_sva.sv ***
// Pin-level checker for the serial frame sequencer
`timescale 1ns/1ps
module sfs_sva
  import sfs_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              arst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic              wr_in,
  input wire logic              serial_clock_line_out,
  input wire logic              serial_clock_line_oe_n_out,
  input wire logic              frame_select_line_out,
  input wire logic              serial_out_line_out,
  input wire logic              serial_out_line_oe_n_out
);
  logic [15:0] ctl;
  logic [7:0]  dv;
  logic [9:0]  c_f;
  logic [9:0]  c_s;
  logic [5:0]  n_r;
  logic        first;
  logic [9:0]  hp;
  logic [5:0]  nbit;
  logic        spi_m;
  logic        sck;
  logic        fss;
  assign sck = serial_clock_line_out;
  assign fss = frame_select_line_out;
  assign hp = 10'(dv) + 10'h001;
  // Sizes below four are forced up to four
  assign nbit = (ctl[11:8] < 4'h3) ? 6'h04 : 6'(ctl[11:8]) + 6'h01;
  assign spi_m = ctl[CTRL_MST] && ctl[CTRL_FMT_HI:CTRL_FMT_LO] == FMT_SPI;
  // Shadow of control and divider, plus edge counters
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctl <= 16'h0700;
      dv <= 8'h04;
      c_f <= 10'h000;
      c_s <= 10'h000;
      n_r <= 6'h00;
      first <= 1'b0;
    end
    else
    begin
      if (wr_in && addr_in == OFS_CTRL)
        ctl <= wdata_in;
      if (wr_in && addr_in == OFS_DIV)
        dv <= wdata_in[7:0];
      c_f <= $fell(fss) ? 10'h001 : c_f + 10'(c_f != 10'h3FF);
      c_s <= $changed(sck) ? 10'h001 : c_s + 10'(c_s != 10'h3FF);
      n_r <= $fell(fss) ? 6'h00 : n_r + 6'($rose(sck));
      first <= $fell(fss) ? 1'b1 : first && !$changed(sck);
    end
  end
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  idle_sck_a: assert property (fss && $past(fss) && ctl[CTRL_MST] && !$past(wr_in)
    && !$past(wr_in, 2) |-> sck == ctl[CTRL_SPO]) else $error("idle clock level wrong");
  idle_tx_a: assert property (serial_out_line_oe_n_out |-> !serial_out_line_out)
    else $error("transmit line not low while pad off");
  clk_pad_a: assert property (!$past(wr_in) && !$past(wr_in, 2) |->
    serial_clock_line_oe_n_out == !ctl[CTRL_MST]) else $error("clock pad enable wrong");
  frame_tx_a: assert property ($fell(fss) && ctl[CTRL_MST] |-> !serial_out_line_oe_n_out)
    else $error("transmit pad off at frame start");
  ph0_lead_a: assert property (first && $changed(sck) && spi_m && !ctl[CTRL_SPH] |->
    c_f == {hp[8:0], 1'b0}) else $error("phase 0 first edge misplaced");
  ph1_lead_a: assert property (first && $changed(sck) && spi_m && ctl[CTRL_SPH] |->
    c_f == hp) else $error("phase 1 first edge misplaced");
  first_dir_a: assert property (first && $changed(sck) && spi_m |->
    sck != ctl[CTRL_SPO]) else $error("first clock edge in wrong direction");
  fss_end_a: assert property ($rose(fss) && spi_m |->
    c_s == (ctl[CTRL_SPH] ? {hp[8:0], 1'b0} : hp)) else $error("select rise mistimed");
  spi_len_a: assert property ($rose(fss) && spi_m && !ctl[CTRL_SPH] |-> n_r == nbit)
    else $error("word bit count wrong");
  cmd_len_a: assert property ($rose(fss) && ctl[CTRL_MST] &&
    ctl[CTRL_FMT_HI:CTRL_FMT_LO] == FMT_CMD |-> n_r == nbit + 6'h09)
    else $error("command frame length wrong");
  cover property ($rose(fss) && spi_m && !ctl[CTRL_SPH]);
  cover property ($rose(fss) && spi_m && ctl[CTRL_SPH]);
  cover property ($rose(fss) && ctl[CTRL_FMT_HI:CTRL_FMT_LO] == FMT_CMD);
endmodule

bind sfs_sequencer sfs_sva u_sva (.*);

// *** testbench/sfs_slave_model.sv ***
// Behavioural off-chip serial slave facing the sequencer
`timescale 1ns/1ps
module sfs_slave_model
(
  input  wire logic        sck_in,
  input  wire logic        fss_n_in,
  input  wire logic        mosi_in,
  input  wire logic        pol_in,
  input  wire logic        pha_in,
  input  wire logic        cmd_in,
  input  wire logic [4:0]  nb_in,
  input  wire logic [15:0] word_in,
  output logic             miso_out,
  output logic [15:0]      got_out
);
  int k;
  initial miso_out = 1'b0;
  // Phase 0 bit out at select fall
  always @(negedge fss_n_in)
  begin
    k = 0;
    got_out = 16'h0000;
    if (!cmd_in && !pha_in)
      miso_out = word_in[nb_in - 1];
  end
  // No pull-up, so released line flips
  always @(posedge fss_n_in)
    miso_out = ~miso_out;
  always @(sck_in)
    if (!fss_n_in)
    begin
      if (cmd_in)
      begin
        // Control latched on rise, answer after one wait clock
        if (sck_in)
        begin
          k++;
          if (k <= 8)
            got_out = {got_out[14:0], mosi_in};
        end
        else if (k >= 9 && k < 9 + nb_in)
          miso_out = word_in[nb_in + 8 - k];
        // Undriven line shows no stable level
        else
          miso_out = ~miso_out;
      end
      else if ((sck_in != pol_in) != pha_in)
      begin
        got_out = {got_out[14:0], mosi_in};
        k++;
      end
      else
        miso_out = word_in[nb_in - 1 - (k % nb_in)];
    end
endmodule

// *** testbench/sfs_sequencer_tb_top.sv ***
// Self-checking bench: register port, four SPI variants, command frames
`timescale 1ns/1ps
module sfs_sequencer_tb_top;
  import sfs_pkg::*;
  logic              clk_in    = 1'b0;
  logic              arst_n_in = 1'b0;
  logic [ADDR_W-1:0] addr_in   = 4'h0;
  logic [DATA_W-1:0] wdata_in  = 16'h0000;
  logic              wr_in     = 1'b0;
  logic              rd_in     = 1'b0;
  logic              rd_d      = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic              sck, sck_oe_n, fss, fss_oe_n, mosi, mosi_oe_n, miso;
  logic              pol = 1'b0, pha = 1'b0, cmd = 1'b0;
  logic [4:0]        nb = 5'h08;
  logic [15:0]       sword = 16'h0000, got, lfsr = 16'h0040;
  logic [DATA_W-1:0] expq[$];
  int                n_mismatch = 0, n_compared = 0, n_rise = 0, n_fss = 0;
  logic              ext_sck = 1'b0, ext_fss = 1'b1, ext_rx = 1'b0, slv = 1'b0;
  wire               rx_w = slv ? ext_rx : miso;

  sfs_sequencer dut_u (
    .clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .serial_clock_line_in(ext_sck), .serial_clock_line_out(sck),
    .serial_clock_line_oe_n_out(sck_oe_n), .frame_select_line_in(ext_fss),
    .frame_select_line_out(fss), .frame_select_line_oe_n_out(fss_oe_n),
    .serial_out_line_out(mosi), .serial_out_line_oe_n_out(mosi_oe_n),
    .serial_in_line_in(rx_w));
  sfs_slave_model slave_u (
    .sck_in(sck), .fss_n_in(fss), .mosi_in(mosi), .pol_in(pol), .pha_in(pha),
    .cmd_in(cmd), .nb_in(nb), .word_in(sword), .miso_out(miso), .got_out(got));

  always #12.5 clk_in = ~clk_in;
  always @(posedge sck)
    if (!fss)
      n_rise++;
  always @(posedge fss)
    n_fss++;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Note the expected read value; the watcher compares it
  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    expq.push_back(e);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask

  always @(posedge clk_in)
  begin
    if (rd_d)
      chk("rdata", expq.pop_front(), rdata_out);
    rd_d <= rd_in;
  end

  // Select must stay high a long while before a frame counts as over
  task automatic frame_done();
    int t;
    t = 0;
    for (int i = 0; i < 3000 && t < 40; i++)
    begin
      @(posedge clk_in);
      t = fss ? t + 1 : 0;
    end
    chk("frame end", 16'h0001, 16'(t >= 40));
  endtask

  task automatic run(input logic [1:0] f, input logic [1:0] m, input logic [3:0] dss,
                     input bit two);
    logic [15:0] ctl, d1, d2, mr, mg;
    ctl = {4'h0, dss, 2'b00, f, m, 2'b10};
    lfsr = lfsr_next(lfsr);
    d1 = lfsr;
    lfsr = lfsr_next(lfsr);
    d2 = lfsr;
    lfsr = lfsr_next(lfsr);
    sword = lfsr;
    mr = 16'hFFFF >> (4'hF - dss);
    cmd = (f == FMT_CMD);
    mg = cmd ? 16'h00FF : mr;
    pol = m[0];
    pha = m[1];
    nb = 5'(dss) + 5'h01;
    n_rise = 0;
    n_fss = 0;
    wreg(OFS_CTRL, ctl);
    wreg(OFS_DATA, d1);
    wreg(OFS_DATA, ~d1);
    rreg(OFS_STAT, 16'h0001);
    // Enable with data waiting starts the frame
    wreg(OFS_CTRL, ctl | 16'h0001);
    if (two)
    begin
      for (int i = 0; i < 20 && fss; i++)
        @(posedge clk_in);
      wreg(OFS_DATA, d2);
    end
    frame_done();
    chk("clock rises", 16'(cmd ? 9 + nb : (two ? 2 : 1) * nb), 16'(n_rise));
    chk("slave word", (two ? d2 : d1) & mg, got & mg);
    chk("select rises", 16'(two && !pha ? 2 : 1), 16'(n_fss));
    rreg(OFS_STAT, two ? 16'h000A : 16'h0002);
    rreg(OFS_DATA, sword & mr);
    rreg(OFS_STAT, 16'h0000);
    wreg(OFS_CTRL, ctl);
  endtask

  // Bench plays master; eight-cycle half period keeps sixteen clocks per bit
  task automatic slv_run();
    logic [15:0] d, v, seen;
    lfsr = lfsr_next(lfsr);
    d = lfsr;
    lfsr = lfsr_next(lfsr);
    v = lfsr;
    seen = 16'h0000;
    slv <= 1'b1;
    wreg(OFS_CTRL, 16'h0701);
    wreg(OFS_DATA, d);
    ext_fss <= 1'b0;
    repeat (8) @(posedge clk_in);
    for (int i = 7; i >= 0; i--)
    begin
      ext_rx <= v[i];
      repeat (8) @(posedge clk_in);
      seen = {seen[14:0], mosi};
      ext_sck <= 1'b1;
      repeat (8) @(posedge clk_in);
      ext_sck <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
    chk("slave pad", 16'h0000, {15'h0000, mosi_oe_n});
    ext_fss <= 1'b1;
    chk("slave out", d & 16'h00FF, seen);
    repeat (8) @(posedge clk_in);
    rreg(OFS_DATA, v & 16'h00FF);
    wreg(OFS_CTRL, 16'h0700);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rreg(OFS_CTRL, 16'h0700);
    rreg(OFS_DIV, 16'h0004);
    rreg(OFS_STAT, 16'h0000);
    rreg(4'h2, 16'h0000);
    // Half period of four cycles gives a 200 ns serial clock
    wreg(OFS_DIV, 16'h0003);
    rreg(OFS_DIV, 16'h0003);
    for (int i = 0; i < 4; i++)
      run(FMT_SPI, 2'(i), 4'(4 * i) + 4'h3, 1'b0);
    for (int i = 0; i < 4; i++)
      run(FMT_SPI, 2'(i), 4'h7, 1'b1);
    run(FMT_CMD, 2'b00, 4'h3, 1'b0);
    run(FMT_CMD, 2'b00, 4'hF, 1'b0);
    slv_run();
    wreg(OFS_CTRL, 16'h0001);
    repeat (3) @(posedge clk_in);
    chk("clock pad", 16'h0001, {15'h0000, sck_oe_n});
    chk("select pad", 16'h0001, {15'h0000, fss_oe_n});
    end_sim();
  end

  initial
  begin
    #(60000 * 25);
    n_mismatch++;
    end_sim();
  end
endmodule
